/* logic/irq_priority_config_status.sv */
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// How it works
// - every source has a writable 3-bit level, 7 is the highest user level
// - level 1 is the lowest active level, 0 keeps the source from requesting
// - one level field for each adc pair conversion-done, pairs 0 to 12
// - one level field for each pwm generator, 1 to 9
// - one level field for each analog comparator, 2 to 4
// - read-only status, reset zero: 4-bit new cpu level, 7-bit vector
// - every level field resets to 4
// - trap levels 8 to 15 are never masked; only user levels are
module irq_priority_config_status
	import irq_prio_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rstn_i,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0]     avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [3:0]            avs_byteenable_i,
	input  wire logic [31:0]           avs_writedata_i,
	output logic      [31:0]           avs_readdata_o,
	output logic                       avs_waitrequest_o,
	// interrupt sources
	input  wire logic [12:0]           adc_pair_req_i,
	input  wire logic [8:0]            pwm_gen_req_i,
	input  wire logic [2:0]            comparator_req_i,
	input  wire logic [TRAP_COUNT-1:0] trap_req_i,
	// cpu side
	input  wire logic [3:0]            cpu_level_i,
	input  wire logic                  cpu_ack_i,
	output logic                       cpu_irq_req_o,
	output logic      [3:0]            cpu_irq_level_o,
	output logic      [6:0]            cpu_irq_vector_o,
	// event interrupt
	output logic                       irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// decode helper

	// true when the bus word index selects the given register
	function automatic logic reg_hit(input word_idx_t word, input word_idx_t idx);
		reg_hit = (word == idx);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	// level fields
	prio_t                 prio_reg [SRC_COUNT];

	// bus answer
	logic                  waitrequest_reg;
	logic                  waitrequest_next;
	logic [31:0]           readdata_reg;
	logic [31:0]           readdata_next;

	// pending status
	logic [3:0]            level_status_reg;
	logic [3:0]            level_status_next;
	logic [6:0]            vector_status_reg;
	logic [6:0]            vector_status_next;

	// request towards the cpu
	logic                  irq_req_reg;
	logic                  irq_req_next;
	logic [3:0]            irq_level_reg;
	logic [3:0]            irq_level_next;
	logic [6:0]            irq_vector_reg;
	logic [6:0]            irq_vector_next;

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	wire word_idx_t word_idx;
	wire            access_w;
	wire            write_fire;
	wire            mapped_w;
	wire            evt_clr_we;
	wire            evt_mask_we;
	wire            low_lane_w;

	// bus timing, one access at a time:
	//  c0  request seen with waitrequest high, read data captured at its end
	//  c1  waitrequest low, a write lands at the end of this cycle
	//  c2  waitrequest high again, the next request may be taken
	// a request is served once: waitrequest drops for exactly one cycle
	assign word_idx    = avs_address_i[5:2];
	assign access_w    = (avs_read_i | avs_write_i) & waitrequest_reg;
	assign write_fire  = avs_write_i & ~waitrequest_reg;
	assign mapped_w    = (word_idx <= IDX_EVT_MASK);
	assign low_lane_w  = avs_byteenable_i[0];
	assign evt_clr_we  = write_fire & low_lane_w & reg_hit(word_idx, IDX_EVT_STATUS);
	assign evt_mask_we = write_fire & low_lane_w & reg_hit(word_idx, IDX_EVT_MASK);

	// word map:
	//  0 adc pairs 8 to 10
	//  1 adc pairs 11 and 12
	//  2 pwm 1 and 2
	//  3 pwm 3 to 6
	//  4 pwm 7 to 9, comparator 2
	//  5 comparators 3 and 4
	//  6 adc pairs 0 and 1
	//  7 adc pairs 2 to 5
	//  8 adc pairs 6 and 7
	//  9 pending level and vector, read only
	//  10 event status, write one to clear
	//  11 event mask
	//  12 to 15 unmapped, read zero
	wire sel_prio_w;
	wire sel_pending_w;
	wire sel_evt_status_w;
	wire sel_evt_mask_w;

	// read selects, at most one is high
	assign sel_prio_w       = mapped_w & (word_idx < IDX_PENDING_STATUS);
	assign sel_pending_w    = mapped_w & reg_hit(word_idx, IDX_PENDING_STATUS);
	assign sel_evt_status_w = mapped_w & reg_hit(word_idx, IDX_EVT_STATUS);
	assign sel_evt_mask_w   = mapped_w & reg_hit(word_idx, IDX_EVT_MASK);

	////////////////////////////////////////////////////////////////////////////
	// priority fields

	wire [SRC_COUNT-1:0] src_req;
	wire [SRC_COUNT-1:0] field_we;
	wire [SRC_COUNT-1:0] src_armed;
	wire [SRC_COUNT-1:0] src_live;

	// source order: adc pairs 0..12, pwm 1..9, comparators 2..4
	assign src_req = {comparator_req_i, pwm_gen_req_i, adc_pair_req_i};

	// only armed sources reach the arbiter
	assign src_live = src_req & src_armed;

	genvar g;
	generate
		for (g = 0; g < SRC_COUNT; g++) begin : gen_field
			// only the lane that holds the field may change it
			assign field_we[g] = write_fire
				& reg_hit(word_idx, FIELD_REG[g])
				& avs_byteenable_i[FIELD_LSB[g] / 8];

			// a level of zero keeps the source away from the arbiter
			assign src_armed[g] = (prio_reg[g] != PRIO_DISABLED);

			// one 3-bit level per source, loaded to level 4 at reset
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					prio_reg[g] <= PRIO_RESET;
				end else if (field_we[g]) begin
					prio_reg[g] <= avs_writedata_i[FIELD_LSB[g] +: 3];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// register readback

	logic [15:0] prio_view [PRIO_REGS];

	// only the level fields appear; every other bit reads zero
	always_comb begin
		for (int r = 0; r < PRIO_REGS; r++) begin
			prio_view[r] = 16'h0000;
		end
		for (int k = 0; k < SRC_COUNT; k++) begin
			prio_view[FIELD_REG[k]][FIELD_LSB[k] +: 3] = prio_reg[k];
		end
	end

	wire [15:0]          pending_view;
	wire [EVT_COUNT-1:0] evt_status;
	wire [EVT_COUNT-1:0] evt_mask;

	// level and vector sit in their fields, the rest reads zero
	// level in bits 11:8, vector in bits 6:0
	assign pending_view = {4'h0, level_status_reg, 1'b0, vector_status_reg};

	// read data multiplexer, unmapped words read zero
	always_comb begin
		readdata_next = 32'h0000_0000;
		if (sel_prio_w) begin
			readdata_next = {16'h0000, prio_view[word_idx]};
		end else if (sel_pending_w) begin
			readdata_next = {16'h0000, pending_view};
		end else if (sel_evt_status_w) begin
			readdata_next = {30'h0000_0000, evt_status};
		end else if (sel_evt_mask_w) begin
			readdata_next = {30'h0000_0000, evt_mask};
		end
	end

	// waitrequest rests high and opens for the answer cycle
	assign waitrequest_next = ~access_w;

	// bus answer registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			waitrequest_reg <= 1'b1;
			readdata_reg    <= 32'h0000_0000;
		end else begin
			waitrequest_reg <= waitrequest_next;
			if (access_w) begin
				readdata_reg <= readdata_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// arbitration among user sources

	wire [2:0]       user_lvl;
	wire [IDX_W-1:0] user_idx;

	// a source with level zero is never a candidate
	// ties go to the lowest source index
	level_pick u_pick (
		.lvl_i      (prio_reg),
		.req_i      (src_live),
		.best_lvl_o (user_lvl),
		.best_idx_o (user_idx)
	);

	wire       user_active;
	wire       user_wins;
	wire       trap_any;
	logic [2:0] trap_sel;

	// level 000 leaves best at zero, so a disabled source never raises a request
	assign user_active = (user_lvl != PRIO_DISABLED);

	// user requests must exceed the cpu level; level 7 or above masks them all
	// an equal level does not interrupt: the cpu already runs there
	assign user_wins = user_active & ({1'b0, user_lvl} > cpu_level_i);

	// any trap request goes through, whatever the cpu level
	// no mask and no level compare on this path
	assign trap_any = |trap_req_i;

	// highest trap bit selects the highest trap level
	always_comb begin
		trap_sel = 3'h0;
		for (int t = 0; t < TRAP_COUNT; t++) begin
			if (trap_req_i[t]) begin
				trap_sel = 3'(t);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request towards the cpu

	wire [3:0] trap_level;
	wire [6:0] trap_vector;
	wire [3:0] user_level;
	wire [6:0] user_vector;

	// candidate level and vector for each kind of source
	assign trap_level  = LEVEL_TRAP_MIN | {1'b0, trap_sel};
	assign trap_vector = VEC_TRAP_BASE + {4'h0, trap_sel};
	assign user_level  = {1'b0, user_lvl};
	assign user_vector = VEC_USER_BASE + {2'b00, user_idx};

	// traps outrank every user level
	always_comb begin
		irq_req_next    = 1'b0;
		irq_level_next  = 4'h0;
		irq_vector_next = 7'h00;
		if (trap_any) begin
			irq_req_next    = 1'b1;
			irq_level_next  = trap_level;
			irq_vector_next = trap_vector;
		end else if (user_wins) begin
			irq_req_next    = 1'b1;
			irq_level_next  = user_level;
			irq_vector_next = user_vector;
		end
	end

	// status captures the level and vector the cpu has just taken
	// the registered request is used: it is the one the cpu saw with its ack
	assign level_status_next  = cpu_ack_i ? irq_level_reg  : level_status_reg;
	assign vector_status_next = cpu_ack_i ? irq_vector_reg : vector_status_reg;

	// cpu request registers, recomputed every cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_req_reg    <= 1'b0;
			irq_level_reg  <= 4'h0;
			irq_vector_reg <= 7'h00;
		end else begin
			irq_req_reg    <= irq_req_next;
			irq_level_reg  <= irq_level_next;
			irq_vector_reg <= irq_vector_next;
		end
	end

	// status registers, read only from the bus
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_status_reg  <= 4'h0;
			vector_status_reg <= 7'h00;
		end else begin
			level_status_reg  <= level_status_next;
			vector_status_reg <= vector_status_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event interrupt

	wire [EVT_COUNT-1:0] evt_in;
	wire                 irq_w;

	// status update and trap presence are the reported events
	// the trap bit sets again every cycle a trap waits, so a clear can lose
	assign evt_in[EVT_ACK]  = cpu_ack_i;
	assign evt_in[EVT_TRAP] = trap_any;

	sticky_irq u_events (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.event_i     (evt_in),
		.clr_we_i    (evt_clr_we),
		.clr_data_i  (avs_writedata_i[EVT_COUNT-1:0]),
		.mask_we_i   (evt_mask_we),
		.mask_data_i (avs_writedata_i[EVT_COUNT-1:0]),
		.status_o    (evt_status),
		.mask_o      (evt_mask),
		.irq_o       (irq_w)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flip-flops

	assign avs_readdata_o    = readdata_reg;
	assign avs_waitrequest_o = waitrequest_reg;
	assign cpu_irq_req_o     = irq_req_reg;
	assign cpu_irq_level_o   = irq_level_reg;
	assign cpu_irq_vector_o  = irq_vector_reg;
	assign irq_o             = irq_w;

endmodule

/* logic/irq_prio_pkg.sv */
package irq_prio_pkg;

	////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int SRC_COUNT  = 25;             // 13 adc pairs, 9 pwm, 3 comparators
	localparam int PRIO_REGS  = 9;              // priority_config_regs
	localparam int TRAP_COUNT = 8;              // trap levels 8..15
	localparam int EVT_COUNT  = 2;
	localparam int ADDR_W     = 6;
	localparam int IDX_W      = 5;

	typedef logic [2:0] prio_t;
	typedef logic [3:0] word_idx_t;

	////////////////////////////////////////////////////////////////////////////
	// register word indices, byte address is four times the index
	localparam word_idx_t IDX_ADC_PAIR8_10     = 4'h0;
	localparam word_idx_t IDX_ADC_PAIR11_12    = 4'h1;
	localparam word_idx_t IDX_PWM1_2           = 4'h2;
	localparam word_idx_t IDX_PWM3_6           = 4'h3;
	localparam word_idx_t IDX_PWM7_9_CMP2      = 4'h4;
	localparam word_idx_t IDX_CMP3_4           = 4'h5;
	localparam word_idx_t IDX_ADC_PAIR0_1      = 4'h6;
	localparam word_idx_t IDX_ADC_PAIR2_5      = 4'h7;
	localparam word_idx_t IDX_ADC_PAIR6_7      = 4'h8;
	localparam word_idx_t IDX_PENDING_STATUS   = 4'h9;
	localparam word_idx_t IDX_EVT_STATUS       = 4'hA;
	localparam word_idx_t IDX_EVT_MASK         = 4'hB;

	////////////////////////////////////////////////////////////////////////////
	// field placement per source: adc pair 0..12, pwm 1..9, comparator 2..4
	localparam word_idx_t FIELD_REG [SRC_COUNT] = '{
		4'h6, 4'h6, 4'h7, 4'h7, 4'h7, 4'h7, 4'h8, 4'h8, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1,
		4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h4, 4'h4, 4'h4,
		4'h4, 4'h5, 4'h5};
	localparam int FIELD_LSB [SRC_COUNT] = '{
		8, 12, 0, 4, 8, 12, 0, 4, 4, 8, 12, 0, 4,
		8, 12, 0, 4, 8, 12, 0, 4, 8,
		12, 0, 4};

	////////////////////////////////////////////////////////////////////////////
	// values and status layout
	localparam prio_t      PRIO_RESET     = 3'h4;
	localparam prio_t      PRIO_DISABLED  = 3'h0;
	localparam logic [3:0] LEVEL_TRAP_MIN = 4'h8;
	localparam logic [6:0] VEC_USER_BASE  = 7'h08;
	localparam logic [6:0] VEC_TRAP_BASE  = 7'h00;
	localparam int         LEVEL_LSB      = 8;
	localparam int         VECTOR_LSB     = 0;
	localparam int         EVT_ACK        = 0;
	localparam int         EVT_TRAP       = 1;

endpackage

/* logic/level_pick.sv */
`timescale 1ns/1ps
module level_pick
	import irq_prio_pkg::*;
(
	input  wire prio_t            lvl_i [SRC_COUNT],
	input  wire logic [SRC_COUNT-1:0] req_i,
	output logic      [2:0]       best_lvl_o,
	output logic      [IDX_W-1:0] best_idx_o
);

	// highest level among requesting sources, lowest index wins a tie
	always_comb begin
		best_lvl_o = PRIO_DISABLED;
		best_idx_o = '0;
		for (int k = 0; k < SRC_COUNT; k++) begin
			if (req_i[k] && (lvl_i[k] > best_lvl_o)) begin
				best_lvl_o = lvl_i[k];
				best_idx_o = IDX_W'(k);
			end
		end
	end

endmodule

/* logic/sticky_irq.sv */
`timescale 1ns/1ps
module sticky_irq
	import irq_prio_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	input  wire logic [EVT_COUNT-1:0] event_i,
	input  wire logic                 clr_we_i,
	input  wire logic [EVT_COUNT-1:0] clr_data_i,
	input  wire logic                 mask_we_i,
	input  wire logic [EVT_COUNT-1:0] mask_data_i,
	output logic      [EVT_COUNT-1:0] status_o,
	output logic      [EVT_COUNT-1:0] mask_o,
	output logic                      irq_o
);

	logic [EVT_COUNT-1:0] status_next;
	logic [EVT_COUNT-1:0] mask_next;

	// write one to clear, a new event in the same cycle wins
	assign status_next = (status_o & ~(clr_we_i ? clr_data_i : '0)) | event_i;
	assign mask_next   = mask_we_i ? mask_data_i : mask_o;

	// status, mask and the level interrupt
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status_o <= '0;
			mask_o   <= '0;
			irq_o    <= 1'b0;
		end else begin
			status_o <= status_next;
			mask_o   <= mask_next;
			irq_o    <= |(status_next & mask_next);
		end
	end

endmodule

/* tb/irq_prio_props.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// checker on the top ports: bus handshake and request selection
module irq_prio_props
	import irq_prio_pkg::*;
(
	input wire logic                  clk_i,
	input wire logic                  rstn_i,
	input wire logic                  avs_read_i,
	input wire logic                  avs_write_i,
	input wire logic [31:0]           avs_readdata_o,
	input wire logic                  avs_waitrequest_o,
	input wire logic [12:0]           adc_pair_req_i,
	input wire logic [8:0]            pwm_gen_req_i,
	input wire logic [2:0]            comparator_req_i,
	input wire logic [TRAP_COUNT-1:0] trap_req_i,
	input wire logic [3:0]            cpu_level_i,
	input wire logic                  cpu_irq_req_o,
	input wire logic [3:0]            cpu_irq_level_o,
	input wire logic [6:0]            cpu_irq_vector_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// a taken request is answered by a single low cycle of waitrequest
	sequence seq_taken;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence seq_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence

	a_bus_answer_once: assert property (seq_taken |=> seq_answer)
		else $error("bus answer not one cycle after request");
	a_wait_has_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
		else $error("waitrequest dropped without request");
	a_upper_read_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0)
		else $error("upper read data not zero");
	a_trap_top_wins: assert property (trap_req_i[7] |=> cpu_irq_req_o && cpu_irq_level_o == 4'hF && cpu_irq_vector_o == 7'h07)
		else $error("top trap not requested");
	a_user_level_masked: assert property (trap_req_i == 8'h00 && cpu_level_i >= 4'h7 |=> !cpu_irq_req_o)
		else $error("user request above cpu level seven");
	a_idle_no_request: assert property ((adc_pair_req_i | pwm_gen_req_i | comparator_req_i | trap_req_i) == '0 |=> !cpu_irq_req_o && cpu_irq_level_o == 4'h0)
		else $error("request without source");
	a_req_level_pair: assert property (cpu_irq_req_o == (cpu_irq_level_o != 4'h0))
		else $error("request and level disagree");
	a_user_vector_range: assert property (cpu_irq_req_o && !cpu_irq_level_o[3] |-> cpu_irq_vector_o >= 7'h08 && cpu_irq_vector_o <= 7'h20)
		else $error("user vector out of range");
endmodule

bind irq_priority_config_status irq_prio_props chk (.clk_i, .rstn_i, .avs_read_i, .avs_write_i,
	.avs_readdata_o, .avs_waitrequest_o, .adc_pair_req_i, .pwm_gen_req_i, .comparator_req_i,
	.trap_req_i, .cpu_level_i, .cpu_irq_req_o, .cpu_irq_level_o, .cpu_irq_vector_o);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import irq_prio_pkg::*;
	logic              clk_i = 1'b0;
	logic              rstn_i = 1'b0;
	logic [ADDR_W-1:0] avs_address_i = '0;
	logic              avs_read_i = 1'b0;
	logic              avs_write_i = 1'b0;
	logic [3:0]        avs_byteenable_i = 4'h0;
	logic [31:0]       avs_writedata_i = '0;
	logic [31:0]       avs_readdata_o;
	logic              avs_waitrequest_o;
	logic [12:0]       adc_pair_req_i = '0;
	logic [8:0]        pwm_gen_req_i = '0;
	logic [2:0]        comparator_req_i = '0;
	logic [7:0]        trap_req_i = '0;
	logic [3:0]        cpu_level_i = 4'h0;
	logic              cpu_ack_i = 1'b0;
	logic              cpu_irq_req_o;
	logic [3:0]        cpu_irq_level_o;
	logic [6:0]        cpu_irq_vector_o;
	logic              irq_o;
	int                miscompares = 0;
	int                comparisons = 0;

	irq_priority_config_status uut (.clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .adc_pair_req_i,
		.pwm_gen_req_i, .comparator_req_i, .trap_req_i, .cpu_level_i, .cpu_ack_i, .cpu_irq_req_o,
		.cpu_irq_level_o, .cpu_irq_vector_o, .irq_o);

	// free running clock
	always #25 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////////
	// expected word with every field of one register at one level
	function automatic logic [31:0] field_word(input word_idx_t idx, input prio_t v);
		field_word = '0;
		for (int k = 0; k < SRC_COUNT; k++) begin
			if (FIELD_REG[k] == idx)
				field_word[FIELD_LSB[k] +: 3] = v;
		end
	endfunction

	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic report(input logic ok, input string what);
		comparisons++;
		if (!ok) begin
			miscompares++;
			$display("[FAIL] %0t %s mismatch", $time, what);
		end
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		report(got === exp, "register");
	endtask

	task automatic chk_cpu(input logic req, input logic [3:0] lvl, input logic [6:0] vec);
		#1;
		report({cpu_irq_req_o, cpu_irq_level_o, cpu_irq_vector_o} === {req, lvl, vec}, "cpu request");
	endtask

	task automatic chk_irq(input logic exp);
		repeat (3) @(posedge clk_i);
		#1;
		report(irq_o === exp, "interrupt line");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input word_idx_t idx, input logic [31:0] wd,
			input logic [3:0] be, output logic [31:0] rd);
		int n;
		@(posedge clk_i);
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_address_i <= {idx, 2'b00};
		avs_writedata_i <= wd;
		avs_byteenable_i <= be;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0)
				break;
		end
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n == 20) begin
			miscompares++;
			print_verdict();
		end
	endtask

	task automatic wr(input word_idx_t idx, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] d;
		bus(1'b1, idx, wd, be, d);
	endtask

	task automatic rd_chk(input word_idx_t idx, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, idx, 32'h0, 4'hF, d);
		chk_reg(d, exp);
	endtask

	// one source to a level, its neighbours at the reset level
	task automatic set_prio(input int k, input prio_t v);
		logic [31:0] d;
		d = field_word(FIELD_REG[k], PRIO_RESET);
		d[FIELD_LSB[k] +: 3] = v;
		wr(FIELD_REG[k], d, 4'hF);
		repeat (3) @(posedge clk_i);
	endtask

	task automatic drive_src(input logic [12:0] adc, input logic [8:0] pwm, input logic [2:0] cmp,
			input logic [7:0] trap, input logic [3:0] lvl);
		@(posedge clk_i);
		adc_pair_req_i <= adc;
		pwm_gen_req_i <= pwm;
		comparator_req_i <= cmp;
		trap_req_i <= trap;
		cpu_level_i <= lvl;
		repeat (3) @(posedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rd_chk(word_idx_t'(i), field_word(word_idx_t'(i), PRIO_RESET));
		end
		rd_chk(IDX_PENDING_STATUS, 32'h0);
		for (int i = 12; i < 16; i++) begin
			rd_chk(word_idx_t'(i), 32'h0);
		end
		$display("test reset values done");
		// all ones land only in the level fields
		for (int i = 0; i < 9; i++) begin
			wr(word_idx_t'(i), 32'hFFFFFFFF, 4'hF);
			rd_chk(word_idx_t'(i), field_word(word_idx_t'(i), 3'h7));
		end
		wr(IDX_ADC_PAIR8_10, 32'h0, 4'h2);
		rd_chk(IDX_ADC_PAIR8_10, field_word(IDX_ADC_PAIR8_10, 3'h7) & 32'h000000FF);
		wr(IDX_PENDING_STATUS, 32'hFFFFFFFF, 4'hF);
		rd_chk(IDX_PENDING_STATUS, 32'h0);
		for (int i = 0; i < 9; i++) begin
			wr(word_idx_t'(i), field_word(word_idx_t'(i), PRIO_RESET), 4'hF);
		end
		$display("test register access done");
		// each source raised alone to the top user level
		drive_src(13'h1FFF, 9'h1FF, 3'h7, 8'h00, 4'h0);
		chk_cpu(1'b1, 4'h4, 7'h08);
		for (int k = 0; k < SRC_COUNT; k++) begin
			set_prio(k, 3'h7);
			chk_cpu(1'b1, 4'h7, VEC_USER_BASE + 7'(k));
			set_prio(k, PRIO_RESET);
		end
		set_prio(0, 3'h1);
		chk_cpu(1'b1, 4'h4, 7'h09);
		drive_src(13'h0001, 9'h0, 3'h0, 8'h00, 4'h0);
		chk_cpu(1'b1, 4'h1, 7'h08);
		drive_src(13'h0001, 9'h0, 3'h0, 8'h00, 4'h1);
		chk_cpu(1'b0, 4'h0, 7'h00);
		set_prio(0, PRIO_DISABLED);
		drive_src(13'h0001, 9'h0, 3'h0, 8'h00, 4'h0);
		chk_cpu(1'b0, 4'h0, 7'h00);
		set_prio(0, 3'h7);
		drive_src(13'h0001, 9'h0, 3'h0, 8'h00, 4'h7);
		chk_cpu(1'b0, 4'h0, 7'h00);
		drive_src(13'h0001, 9'h0, 3'h0, 8'h00, 4'h6);
		chk_cpu(1'b1, 4'h7, 7'h08);
		$display("test priority selection done");
		// acknowledge latches status and raises the event
		@(posedge clk_i);
		cpu_ack_i <= 1'b1;
		@(posedge clk_i);
		cpu_ack_i <= 1'b0;
		rd_chk(IDX_PENDING_STATUS, 32'h00000708);
		rd_chk(IDX_EVT_STATUS, 32'h1);
		chk_irq(1'b0);
		wr(IDX_EVT_MASK, 32'h1, 4'h1);
		rd_chk(IDX_EVT_MASK, 32'h1);
		wr(IDX_EVT_MASK, 32'h0, 4'h2);
		rd_chk(IDX_EVT_MASK, 32'h1);
		chk_irq(1'b1);
		wr(IDX_EVT_STATUS, 32'h1, 4'h1);
		chk_irq(1'b0);
		rd_chk(IDX_EVT_STATUS, 32'h0);
		$display("test status and event done");
		// traps ignore the cpu level
		drive_src(13'h0001, 9'h0, 3'h0, 8'h80, 4'hF);
		chk_cpu(1'b1, 4'hF, 7'h07);
		drive_src(13'h0001, 9'h0, 3'h0, 8'h05, 4'hF);
		chk_cpu(1'b1, 4'hA, 7'h02);
		rd_chk(IDX_EVT_STATUS, 32'h2);
		wr(IDX_EVT_STATUS, 32'h2, 4'h1);
		rd_chk(IDX_EVT_STATUS, 32'h2);
		$display("test traps done");
		print_verdict();
	end
endmodule
